// *** rtl/ccr_pkg.sv ***
// Package with constants and types for the converter configuration and reset block.
// Summary of operation
// - Control bit d2 removes the input high-pass filter when 0 and inserts it when 1.
// - Control bit d3 disables the internal loopback path when 0 and enables it when 1.
// - Control bit d4 disables the auxiliary differential input when 0 and enables it when 1.
// - Control bit d5 runs transmit and receive timing independently when 0 and locked together when 1.
// - Control bits d7 and d6 form the two-bit gain selection field.
// - Control bit d9 bypasses the sin(x)/x correction filter when 0 and inserts it when 1.
// - Reset initializes every configuration register, the control register included.
// - A low pulse on reset loads defaults that give an 8 kHz rate from a 5.184 MHz master clock.
// - Reset loads both A dividers with 9, both A adjust registers with 1 and both B dividers with 24 hex.
// - Reset sets d9, d7, d6, d5 and d2 and clears d4 and d3.
// - In synchronous mode receive timing follows the transmit A, adjust and B registers.
// - When A plus its adjust equals 0 or 1, counter A is reloaded with the plain A value.
// - When A plus its adjust is negative, 40 hex is added before counter A is loaded.
// - A B divider written as 0 or 1 is replaced by 24 hex, for transmit and receive alike.
// - When no complete word arrives from the host, the last converter output code is held.
package ccr_pkg;
    localparam int WORD_W  = 17;
    localparam int SEL_W   = 3;
    localparam int DATA_W  = 14;
    localparam int CNT_W   = 5;
    localparam int DIV_W   = 6;
    localparam int CTRL_W  = 10;
    localparam int GAIN_W  = 2;
    localparam int DAC_W   = 14;
    localparam int MCLK_DIV = 2;
    localparam int PRE_W   = 1;

    localparam logic [SEL_W-1:0] SEL_CTRL = 3'h0;
    localparam logic [SEL_W-1:0] SEL_TX_A = 3'h1;
    localparam logic [SEL_W-1:0] SEL_RX_A = 3'h4;
    localparam logic [SEL_W-1:0] SEL_DAC  = 3'h7;

    localparam int CTRL_HP_BIT   = 2;
    localparam int CTRL_LOOP_BIT = 3;
    localparam int CTRL_AUX_BIT  = 4;
    localparam int CTRL_SYNC_BIT = 5;
    localparam int CTRL_GAIN_LSB = 6;
    localparam int CTRL_SINX_BIT = 9;

    localparam logic [CTRL_W-1:0] CTRL_RST  = 10'h2E4;
    localparam logic [CTRL_W-1:0] CTRL_MASK = 10'h2FC;
    localparam logic [DIV_W-1:0]  A_RST     = 6'h09;
    localparam logic [DIV_W-1:0]  ADJ_RST   = 6'h01;
    localparam logic [DIV_W-1:0]  B_RST     = 6'h24;
    localparam logic [DIV_W-1:0]  B_SUBST   = 6'h24;
    localparam logic [DIV_W:0]    MOD_ADD   = 7'h40;
    localparam logic [DAC_W-1:0]  DAC_RST   = 14'h0000;

    typedef struct packed {
        logic [SEL_W-1:0]  sel;
        logic [DATA_W-1:0] data;
    } ccr_cmd_t;

    typedef struct packed {
        logic [DIV_W-1:0] a;
        logic [DIV_W-1:0] adj;
        logic [DIV_W-1:0] b;
    } ccr_div_t;

    typedef enum logic [1:0] {
        LK_IDLE  = 2'b01,
        LK_SHIFT = 2'b10
    } ccr_link_st_t;
endpackage

// *** rtl/ccr_sync.sv ***
// Two-flop synchroniser for a level entering the master clock domain.
`timescale 1ns/1ps
module ccr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// *** rtl/ccr_reload.sv ***
// Reload value for a conversion counter A, with the adjust and its safeguards.
`timescale 1ns/1ps
module ccr_reload (
    input  wire logic [ccr_pkg::DIV_W-1:0] a,
    input  wire logic [ccr_pkg::DIV_W-1:0] adj,
    input  wire logic                      use_adj,
    output logic      [ccr_pkg::DIV_W-1:0] load
);
    import ccr_pkg::*;

    // The adjust is two's complement, so A minus A' is an adjust below zero.
    wire logic [DIV_W:0] sum_w   = {1'b0, a} + {adj[DIV_W-1], adj};
    wire logic           tiny_w  = (sum_w == 7'h00) || (sum_w == 7'h01);
    wire logic           neg_w   = sum_w[DIV_W];
    wire logic [DIV_W:0] wrap_w  = sum_w + MOD_ADD;

    assign load = !use_adj ? a :
                  tiny_w   ? a :
                  neg_w    ? wrap_w[DIV_W-1:0] :
                  sum_w[DIV_W-1:0];
endmodule

// *** rtl/ccr_codec_cfg.sv ***
// Converter configuration registers, reset defaults and conversion timing.
`timescale 1ns/1ps
module ccr_codec_cfg (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    input  wire logic                        link_clk,
    input  wire logic                        frame_sync_b,
    input  wire logic                        serial_data_to_device,
    output logic                             hp_filter_en_q,
    output logic                             loopback_en_q,
    output logic                             aux_in_en_q,
    output logic                             sync_mode_q,
    output logic [ccr_pkg::GAIN_W-1:0]       gain_sel_q,
    output logic                             sinx_corr_en_q,
    output logic                             tx_conv_q,
    output logic                             rx_conv_q,
    output logic [ccr_pkg::DAC_W-1:0]        dac_code_q
);
    import ccr_pkg::*;

    // Link side: words are shifted in on the host's clock, most significant bit first.
    ccr_link_st_t     st_q;
    ccr_link_st_t     st_d;
    logic [WORD_W-1:0] sh_q;
    logic [CNT_W-1:0]  bit_q;
    logic [CNT_W-1:0]  bit_d;
    ccr_cmd_t          word_q;
    logic              tog_q;

    wire logic              frame_on = !frame_sync_b;
    wire logic              last_bit = bit_q == CNT_W'(WORD_W - 1);
    wire logic [WORD_W-1:0] sh_d     = {sh_q[WORD_W-2:0], serial_data_to_device};
    wire logic              cap      = (st_q == LK_SHIFT) && frame_on && last_bit;

    always_comb
    begin
        st_d  = st_q;
        bit_d = bit_q;
        case (st_q)
            LK_IDLE:
            begin
                if (frame_on)
                begin
                    st_d  = LK_SHIFT;
                    bit_d = 5'h01;
                end
            end
            LK_SHIFT:
            begin
                // A frame that ends early is dropped and nothing is written.
                if (!frame_on || last_bit)
                begin
                    st_d  = LK_IDLE;
                end
                else
                begin
                    bit_d = bit_q + 5'h01;
                end
            end
            default:
            begin
                st_d = LK_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q  <= LK_IDLE;
            bit_q <= 5'h00;
            sh_q  <= '0;
        end
        else
        begin
            st_q  <= st_d;
            bit_q <= bit_d;
            sh_q  <= frame_on ? sh_d : sh_q;
        end
    end

    // The word stays put until the next full frame, long after the core has read it.
    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            word_q <= '0;
            tog_q  <= 1'b0;
        end
        else
        begin
            word_q <= cap ? ccr_cmd_t'(sh_d) : word_q;
            tog_q  <= tog_q ^ cap;
        end
    end

    // Core side: a toggle crossing announces each new word.
    logic tog_s;
    logic seen_q;

    ccr_sync #(
        .W (1)
    ) u_tog_sync (
        .clk   (ref_clk),
        .rst_b (rst_b),
        .d     (tog_q),
        .q     (tog_s)
    );

    wire logic new_word = tog_s ^ seen_q;

    function automatic logic hit(input ccr_cmd_t c, input logic [SEL_W-1:0] s);
        hit = c.sel == s;
    endfunction

    wire logic wr_ctrl = new_word && hit(word_q, SEL_CTRL);
    wire logic wr_dac  = new_word && hit(word_q, SEL_DAC);

    logic [CTRL_W-1:0] ctrl_q;
    wire logic [CTRL_W-1:0] ctrl_d = wr_ctrl ? (word_q.data[CTRL_W-1:0] & CTRL_MASK) : ctrl_q;

    logic [PRE_W-1:0] pre_q;
    wire logic        tick  = pre_q == PRE_W'(MCLK_DIV - 1);
    wire logic [PRE_W-1:0] pre_d = tick ? '0 : pre_q + 1'b1;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            seen_q <= 1'b0;
            ctrl_q <= CTRL_RST;
            pre_q  <= '0;
        end
        else
        begin
            seen_q <= tog_s;
            ctrl_q <= ctrl_d;
            pre_q  <= pre_d;
        end
    end

    assign hp_filter_en_q = ctrl_q[CTRL_HP_BIT];
    assign loopback_en_q  = ctrl_q[CTRL_LOOP_BIT];
    assign aux_in_en_q    = ctrl_q[CTRL_AUX_BIT];
    assign sync_mode_q    = ctrl_q[CTRL_SYNC_BIT];
    assign gain_sel_q     = ctrl_q[CTRL_GAIN_LSB +: GAIN_W];
    assign sinx_corr_en_q = ctrl_q[CTRL_SINX_BIT];

    // One timing channel each for transmit (0) and receive (1).
    logic [1:0] ev_w;

    for (genvar g = 0; g < 2; g++)
    begin : g_ch
        localparam logic [SEL_W-1:0] BASE = (g == 0) ? SEL_TX_A : SEL_RX_A;

        ccr_div_t         div_q;
        ccr_div_t         div_d;
        logic             pend_q;
        logic [DIV_W-1:0] cnt_a_q;
        logic [DIV_W-1:0] cnt_b_q;
        logic [DIV_W-1:0] load_w;

        wire logic wr_a   = new_word && hit(word_q, BASE);
        wire logic wr_adj = new_word && hit(word_q, BASE + 3'h1);
        wire logic wr_b   = new_word && hit(word_q, BASE + 3'h2);
        wire logic [DIV_W-1:0] b_in = word_q.data[DIV_W-1:0];

        // An A divider of 0 or 1 shuts the channel down.
        wire logic run   = div_q.a > 6'h01;
        wire logic a_end = run && tick && (cnt_a_q <= 6'h01);
        wire logic b_end = a_end && (cnt_b_q <= 6'h01);

        assign div_d.a   = wr_a ? word_q.data[DIV_W-1:0] : div_q.a;
        assign div_d.adj = wr_adj ? word_q.data[DIV_W-1:0] : div_q.adj;
        assign div_d.b   = !wr_b ? div_q.b : (b_in <= 6'h01) ? B_SUBST : b_in;

        // Each adjust write shortens or stretches one A period only.
        ccr_reload u_reload (
            .a       (div_q.a),
            .adj     (div_q.adj),
            .use_adj (pend_q),
            .load    (load_w)
        );

        wire logic [DIV_W-1:0] cnt_a_d = a_end ? load_w :
                                         (run && tick) ? cnt_a_q - 6'h01 : cnt_a_q;
        wire logic [DIV_W-1:0] cnt_b_d = b_end ? div_q.b :
                                         a_end ? cnt_b_q - 6'h01 : cnt_b_q;

        always_ff @(posedge ref_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                div_q   <= '{a: A_RST, adj: ADJ_RST, b: B_RST};
                pend_q  <= 1'b0;
                cnt_a_q <= A_RST;
                cnt_b_q <= B_RST;
            end
            else
            begin
                div_q   <= div_d;
                pend_q  <= wr_adj | (pend_q & ~a_end);
                cnt_a_q <= cnt_a_d;
                cnt_b_q <= cnt_b_d;
            end
        end

        assign ev_w[g] = b_end;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_conv_q  <= 1'b0;
            rx_conv_q  <= 1'b0;
            dac_code_q <= DAC_RST;
        end
        else
        begin
            tx_conv_q  <= ev_w[0];
            rx_conv_q  <= sync_mode_q ? ev_w[0] : ev_w[1];
            dac_code_q <= wr_dac ? word_q.data : dac_code_q;
        end
    end

    // Checks on the core clock.
    logic init_q;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            init_q <= 1'b0;
        end
        else
        begin
            init_q <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking

    default disable iff (!rst_b);

    property p_hp;
        wr_ctrl |=> hp_filter_en_q == $past(word_q.data[CTRL_HP_BIT]);
    endproperty
    a_hp: assert property (p_hp) else $error("High-pass enable does not follow d2.");

    property p_loop;
        wr_ctrl |=> loopback_en_q == $past(word_q.data[CTRL_LOOP_BIT]);
    endproperty
    a_loop: assert property (p_loop) else $error("Loopback enable does not follow d3.");

    property p_aux;
        wr_ctrl |=> aux_in_en_q == $past(word_q.data[CTRL_AUX_BIT]);
    endproperty
    a_aux: assert property (p_aux) else $error("Auxiliary input enable does not follow d4.");

    property p_sync;
        wr_ctrl |=> sync_mode_q == $past(word_q.data[CTRL_SYNC_BIT]);
    endproperty
    a_sync: assert property (p_sync) else $error("Synchronous mode does not follow d5.");

    property p_gain;
        wr_ctrl |=> gain_sel_q == $past(word_q.data[7:6]);
    endproperty
    a_gain: assert property (p_gain) else $error("Gain field does not follow d7 and d6.");

    property p_sinx;
        wr_ctrl |=> sinx_corr_en_q == $past(word_q.data[CTRL_SINX_BIT]);
    endproperty
    a_sinx: assert property (p_sinx) else $error("Correction filter enable does not follow d9.");

    property p_unused;
        wr_ctrl |=> (ctrl_q[1:0] == 2'b00) && !ctrl_q[8];
    endproperty
    a_unused: assert property (p_unused) else $error("An unused control bit was stored.");

    property p_defaults;
        !init_q |-> ctrl_q == 10'h2E4 && g_ch[0].div_q == {6'h09, 6'h01, 6'h24}
                    && g_ch[1].div_q == {6'h09, 6'h01, 6'h24};
    endproperty
    a_defaults: assert property (p_defaults) else $error("Reset defaults are wrong.");

    property p_follow;
        sync_mode_q && $past(sync_mode_q) |-> rx_conv_q == tx_conv_q;
    endproperty
    a_follow: assert property (p_follow) else $error("Receive timing does not follow transmit.");

    property p_small;
        g_ch[0].pend_q && ({1'b0, g_ch[0].div_q.a} + {g_ch[0].div_q.adj[5], g_ch[0].div_q.adj} <= 7'h01)
            |-> g_ch[0].load_w == g_ch[0].div_q.a;
    endproperty
    a_small: assert property (p_small) else $error("Small adjusted value not replaced by A.");

    property p_wrap;
        g_ch[0].pend_q && g_ch[0].div_q.adj[5] && (g_ch[0].div_q.a < (6'h00 - g_ch[0].div_q.adj))
            |-> {1'b0, g_ch[0].load_w} == {1'b0, g_ch[0].div_q.a} + {1'b1, g_ch[0].div_q.adj} + 7'h40;
    endproperty
    a_wrap: assert property (p_wrap) else $error("Negative adjusted value not wrapped by 40 hex.");

    property p_bsub;
        new_word && hit(word_q, 3'h3) && (word_q.data[5:0] <= 6'h01) |=> g_ch[0].div_q.b == 6'h24;
    endproperty
    a_bsub: assert property (p_bsub) else $error("Transmit B of 0 or 1 not replaced by 24 hex.");

    property p_hold;
        !wr_dac |=> $stable(dac_code_q);
    endproperty
    a_hold: assert property (p_hold) else $error("Converter code changed without a word.");

    property p_dac;
        wr_dac |=> dac_code_q == $past(word_q.data);
    endproperty
    a_dac: assert property (p_dac) else $error("Converter code not taken from the written word.");

    property p_async;
        !sync_mode_q |=> rx_conv_q == $past(ev_w[1]);
    endproperty
    a_async: assert property (p_async) else $error("Receive strobe not from its own channel.");

    property p_bsub_rx;
        new_word && hit(word_q, 3'h6) && (word_q.data[5:0] <= 6'h01) |=> g_ch[1].div_q.b == 6'h24;
    endproperty
    a_bsub_rx: assert property (p_bsub_rx) else $error("Receive B of 0 or 1 not replaced by 24 hex.");

    property p_bkeep;
        new_word && hit(word_q, 3'h3) && (word_q.data[5:0] > 6'h01) |=> g_ch[0].div_q.b == $past(word_q.data[5:0]);
    endproperty
    a_bkeep: assert property (p_bkeep) else $error("Valid transmit B not stored as written.");

    property p_pulse;
        tx_conv_q |=> !tx_conv_q;
    endproperty
    a_pulse: assert property (p_pulse) else $error("Transmit strobe longer than one cycle.");

    property p_cnt_rst;
        !init_q |-> g_ch[0].cnt_a_q == 6'h09 && g_ch[0].cnt_b_q == 6'h24
                    && g_ch[1].cnt_a_q == 6'h09 && g_ch[1].cnt_b_q == 6'h24;
    endproperty
    a_cnt_rst: assert property (p_cnt_rst) else $error("Counters not loaded with defaults.");
endmodule

// *** verification/ccr_host_model.sv ***
// Host serial port model that writes words into the converter configuration block.
`timescale 1ns/1ps
module ccr_host_model (
    output logic link_clk,
    output logic frame_sync_b,
    output logic serial_data_to_device
);
    initial
    begin
        link_clk              = 1'b0;
        serial_data_to_device = 1'b0;
        frame_sync_b          = 1'b1;
    end

    // One link clock period; the clock stands still between calls.
    task automatic tick();
    begin
        #32 link_clk = 1'b1;
        #32 link_clk = 1'b0;
    end
    endtask

    // Frame stays high and the released data line changes once in every idle clock period.
    task automatic idle(input int n);
    begin
        frame_sync_b = 1'b1;
        repeat (n)
        begin
            serial_data_to_device = ~serial_data_to_device;
            tick();
        end
    end
    endtask

    // Sends the top nbits of a word, most significant first; fewer than 17 bits cut the frame short.
    task automatic send_word(input logic [16:0] w, input int nbits);
    begin
        for (int i = 16; i > 16 - nbits; i--)
        begin
            frame_sync_b          = 1'b0;
            serial_data_to_device = w[i];
            tick();
        end
        idle(2);
    end
    endtask
endmodule

// *** verification/codec_config_and_reset_test.sv ***
// Self-checking bench for the converter configuration and reset block.
`timescale 1ns/1ps
module codec_config_and_reset_test;
    import ccr_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rst_b   = 1'b0;
    wire               link_clk;
    wire               frame_sync_b;
    wire               serial_data_to_device;
    logic              hp_q, loop_q, aux_q, sync_q, sinx_q, tx_q, rx_q;
    logic [GAIN_W-1:0] gain_q;
    logic [DAC_W-1:0]  dac_q;
    int                miscompares = 0;
    int                tests_run   = 0;
    int                rx_bad      = 0;
    int                rx_seen     = 0;
    int                seed        = 32'h3889;
    int                n;
    logic [DATA_W-1:0] val;
    logic [DIV_W-1:0]  adj_tab [4] = '{6'h03, 6'h37, 6'h38, 6'h34};

    always #25 ref_clk = ~ref_clk;

    ccr_host_model i_host (
        .link_clk              (link_clk),
        .frame_sync_b          (frame_sync_b),
        .serial_data_to_device (serial_data_to_device)
    );

    ccr_codec_cfg i_dut (
        .ref_clk               (ref_clk),
        .rst_b                 (rst_b),
        .link_clk              (link_clk),
        .frame_sync_b          (frame_sync_b),
        .serial_data_to_device (serial_data_to_device),
        .hp_filter_en_q        (hp_q),
        .loopback_en_q         (loop_q),
        .aux_in_en_q           (aux_q),
        .sync_mode_q           (sync_q),
        .gain_sel_q            (gain_q),
        .sinx_corr_en_q        (sinx_q),
        .tx_conv_q             (tx_q),
        .rx_conv_q             (rx_q),
        .dac_code_q            (dac_q)
    );

    task automatic results();
    begin
        if (miscompares == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    // Control bits as seen at the outputs: d9, d7, d6, d5, d4, d3, d2.
    function automatic logic [6:0] ctrl_view(input logic [9:0] d);
        return {d[9], d[7], d[6], d[5], d[4], d[3], d[2]};
    endfunction

    // Counter A load for an adjusted period with its safeguards.
    function automatic int adj_load(input int a, input logic [DIV_W-1:0] adj);
        int s;
        s = a + int'($signed(adj));
        if (s == 0 || s == 1)
            return a;
        if (s < 0)
            return s + 64;
        return s;
    endfunction

    // Counts ref_clk cycles up to the k-th next transmit strobe, watching the receive strobe.
    task automatic span(input int k, output int cnt);
        int lim;
    begin
        cnt = 0;
        lim = 0;
        repeat (k)
        begin
            do
            begin
                @(negedge ref_clk);
                cnt++;
                lim++;
                if (rx_q !== tx_q)
                    rx_bad++;
                if (rx_q === 1'b1)
                    rx_seen++;
            end while (tx_q !== 1'b1 && lim < 4000);
        end
        if (lim >= 4000)
        begin
            miscompares++;
            results();
        end
    end
    endtask

    task automatic wr(input logic [SEL_W-1:0] sel, input logic [DATA_W-1:0] d);
    begin
        i_host.send_word({sel, d}, 17);
        repeat (8) @(negedge ref_clk);
    end
    endtask

    task automatic chk_ctrl(input logic [9:0] d);
    begin
        check({sinx_q, gain_q, sync_q, aux_q, loop_q, hp_q}, ctrl_view(d));
    end
    endtask

    initial
    begin
        i_host.idle(3);
        repeat (17) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        check({sinx_q, gain_q, sync_q, aux_q, loop_q, hp_q}, 7'h79);
        check(dac_q, 14'h0000);
        span(2, n);
        rx_bad = 0;
        span(1, n);
        check(n, 2 * 9 * 36);
        check(rx_bad, 0);
        wr(3'h1, 14'h0004);
        span(2, n);
        rx_bad = 0;
        span(1, n);
        check(n, 2 * 4 * 36);
        check(rx_bad, 0);
        wr(3'h1, 14'h0009);
        span(2, n);
        foreach (adj_tab[i])
        begin
            fork
                i_host.send_word({3'h2, 8'h00, adj_tab[i]}, 17);
                span(3, n);
            join
            check(n, 3 * 648 + 2 * (adj_load(9, adj_tab[i]) - 9));
        end
        for (int b = 0; b < 2; b++)
        begin
            wr(3'h3, 14'h0012);
            span(2, n);
            span(1, n);
            check(n, 2 * 9 * 18);
            wr(3'h3, 14'(b));
            span(2, n);
            span(1, n);
            check(n, 2 * 9 * 36);
        end
        wr(SEL_CTRL, 14'h03FF);
        chk_ctrl(10'h3FF);
        wr(SEL_CTRL, 14'h0000);
        chk_ctrl(10'h000);
        repeat (6)
        begin
            val = 14'($random(seed));
            wr(SEL_CTRL, val);
            chk_ctrl(val[9:0]);
        end
        wr(SEL_CTRL, 14'h02C4);
        wr(3'h6, 14'h0000);
        wr(3'h6, 14'h0012);
        span(3, n);
        rx_seen = 0;
        span(1, n);
        check(n, 2 * 9 * 36);
        check(rx_seen, 2);
        val = 14'($random(seed));
        wr(SEL_DAC, val);
        check(dac_q, val);
        i_host.send_word({SEL_DAC, ~val}, 12);
        repeat (8) @(negedge ref_clk);
        check(dac_q, val);
        i_host.send_word({SEL_CTRL, 14'h0000}, 16);
        repeat (8) @(negedge ref_clk);
        chk_ctrl(10'h2C4);
        wr(3'h1, 14'h0004);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        i_host.idle(2);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        check({sinx_q, gain_q, sync_q, aux_q, loop_q, hp_q}, 7'h79);
        check(dac_q, 14'h0000);
        span(1, n);
        span(1, n);
        check(n, 2 * 9 * 36);
        results();
    end
endmodule
